// ===== hw/fcts_supervisor.sv
// top: fieldbus control timeout supervisor with axi4-lite registers
//
// Contract
// RL1 - cyclic, connected-zero use connection timeout
// RL2 - watchdog action may alter connection expiry
// RL3 - explicit: value times 100ms, 65535 never
// RL4 - unconnected with zero always timed out
// RL5 - assembly, control bit, reference writes restart
// RL6 - supervisor object reset restarts supervision
// RL7 - force fault write restarts supervision
// RL8 - expiry asserts communication lost to drive
// RL9 - accept run/idle, idle action default zero
// RL10 - idle action zero: idle means comm lost
// RL11 - idle action one: idle keeps comm up
// RL12 - value governs unconnected, dropped connected only
// RL13 - 100ms prescaler, counter cleared on events
// RL14 - lost holds until event or run note
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
module fcts_supervisor
    import fcts_pkg::*;
#(
    parameter int TICK_CYCLES = FCTS_TICK_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic comm_lost,
    output logic irq
);
    // ==========================================================
    // write channel capture: address and data in either order
    logic aw_held_q, w_held_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            awaddr_q <= 8'h00;
        end else if (aw_take) begin
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else if (w_take) begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_q <= 1'b0;
        end
    end

    // each ready only while its own channel holds nothing; one write in flight at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_q && !aw_take && !s_axi_awready;
            s_axi_wready <= !w_held_q && !w_take && !s_axi_wready;
        end
    end

    // ==========================================================
    // write decode
    wire wa_ctrl = (awaddr_q == FCTS_OFF_CTRL);
    wire wa_event = (awaddr_q == FCTS_OFF_EVENT);
    wire wa_stat = (awaddr_q == FCTS_OFF_IRQ_STAT);
    wire wa_mask = (awaddr_q == FCTS_OFF_IRQ_MASK);
    wire wa_conn = (awaddr_q == FCTS_OFF_CONN_TMO);
    wire wa_ro = (awaddr_q == FCTS_OFF_STATUS);
    wire wa_ok = wa_ctrl | wa_event | wa_stat | wa_mask | wa_conn | wa_ro;
    wire wr_ctrl = wr_fire && wa_ctrl;
    wire wr_event = wr_fire && wa_event;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wa_ok ? 2'b00 : 2'b10;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ==========================================================
    // configuration: timeout value, idle action, connection kind
    logic [15:0] tmo_q;
    logic idle_act_q; // see RL9
    logic [1:0] conn_q;
    logic drop_q;
    logic [15:0] conn_tmo_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tmo_q <= FCTS_TMO_RESET;
            idle_act_q <= FCTS_IDLE_RESET; // see RL9
            conn_q <= FCTS_CONN_NONE;
            drop_q <= 1'b0;
        end else if (wr_ctrl) begin
            if (wstrb_q[0]) tmo_q[7:0] <= wdata_q[7:0];
            if (wstrb_q[1]) tmo_q[15:8] <= wdata_q[15:8];
            if (wstrb_q[2]) begin
                idle_act_q <= wdata_q[FCTS_CTRL_IDLE_BIT];
                conn_q <= wdata_q[FCTS_CTRL_CONN_LSB +: 2];
                drop_q <= wdata_q[FCTS_CTRL_DROP_BIT];
            end
        end
    end

    // rpi times multiplier, in ticks, computed by the stack
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conn_tmo_q <= 16'h0000;
        end else if (wr_fire && wa_conn) begin
            if (wstrb_q[0]) conn_tmo_q[7:0] <= wdata_q[7:0];
            if (wstrb_q[1]) conn_tmo_q[15:8] <= wdata_q[15:8];
        end
    end

    // ==========================================================
    // event decode from the event register
    wire [FCTS_EV_WIDTH-1:0] ev = wr_event ? wdata_q[FCTS_EV_WIDTH-1:0]
                                           : '0;
    wire ev_ctrl = |ev[FCTS_EV_TORQUE_REF:FCTS_EV_ASSEMBLY]; // see RL5
    wire ev_obj = ev[FCTS_EV_SUP_RESET] | ev[FCTS_EV_FORCE_FAULT]; // see RL6
    wire ev_force = ev[FCTS_EV_FORCE_FAULT]; // see RL7
    wire control_event = ev_ctrl | ev_obj | ev_force;
    wire ev_idle = ev[FCTS_EV_IDLE];
    wire ev_run = ev[FCTS_EV_RUN_NOTE];
    wire ev_conn_exp = ev[FCTS_EV_CONN_EXPIRE];

    // ==========================================================
    // timeout source selection
    wire is_io = (conn_q == FCTS_CONN_IO);
    wire is_conn = (conn_q == FCTS_CONN_CONNECTED);
    wire is_unconn = (conn_q == FCTS_CONN_UNCONNECTED);
    wire tmo_zero = (tmo_q == 16'h0000);
    wire tmo_never = (tmo_q == FCTS_TMO_NEVER);
    // value governs unconnected, and connected only when dropped
    wire use_value = is_unconn || (is_conn && drop_q); // see RL12
    // cyclic, or connected with zero, use the connection timeout
    wire use_conn = is_io || (is_conn && (tmo_zero || !drop_q)); // see RL1
    wire [15:0] limit = use_conn ? conn_tmo_q : tmo_q; // see RL1
    wire cnt_en = (use_conn && conn_tmo_q != 16'h0000)
               || (use_value && !tmo_zero && !tmo_never); // see RL3
    wire always_out = is_unconn && tmo_zero; // see RL4

    // ==========================================================
    // 100 ms tick and supervision counter
    logic tick;
    logic expired;

    fcts_prescaler #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_presc (
        .aclk(aclk),
        .aresetn(aresetn),
        .restart(control_event), // see RL13
        .tick(tick)
    );

    fcts_timeout_counter u_count (
        .aclk(aclk),
        .aresetn(aresetn),
        .clear(control_event || wr_ctrl), // see RL13
        .tick(tick),
        .limit(limit),
        .enable(cnt_en),
        .expired(expired)
    );

    // ==========================================================
    // communication-lost level
    // watchdog action reported by the stack overrides connection expiry
    wire conn_expire = use_conn && ev_conn_exp; // see RL2
    wire lose_idle = ev_idle && !idle_act_q; // see RL10
    // a control event clears the counter, so expiry seen with it is stale
    wire expire_now = expired && !control_event; // see RL14
    wire lose = expire_now || always_out || conn_expire
             || lose_idle; // see RL8
    wire regain = control_event || (ev_run && !always_out); // see RL14
    logic idle_lost_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            comm_lost <= 1'b0;
        end else if (lose) begin
            comm_lost <= 1'b1; // see RL8
        end else if (regain) begin
            comm_lost <= 1'b0; // see RL14
        end
    end
    // online idle leaves comm_lost untouched: see RL11
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idle_lost_q <= 1'b0;
        end else begin
            idle_lost_q <= lose_idle;
        end
    end

    // ==========================================================
    // sticky interrupt status, write one to clear, set wins
    logic [FCTS_IRQ_WIDTH-1:0] stat_q, mask_q;
    wire [FCTS_IRQ_WIDTH-1:0] stat_set = {ev_idle, expired, lose};
    wire [FCTS_IRQ_WIDTH-1:0] stat_clr = (wr_fire && wa_stat && wstrb_q[0])
        ? wdata_q[FCTS_IRQ_WIDTH-1:0] : '0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_q <= '0;
            mask_q <= '0;
            irq <= 1'b0;
        end else begin
            stat_q <= (stat_q & ~stat_clr) | stat_set;
            if (wr_fire && wa_mask && wstrb_q[0])
                mask_q <= wdata_q[FCTS_IRQ_WIDTH-1:0];
            irq <= |(((stat_q & ~stat_clr) | stat_set) & mask_q);
        end
    end

    // ==========================================================
    // read channel
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire [31:0] rd_ctrl = {12'h000, drop_q, conn_q, idle_act_q, tmo_q};
    wire [31:0] rd_status = {28'h0, idle_lost_q, always_out, expired,
                             comm_lost};
    wire ra_ok = (s_axi_araddr == FCTS_OFF_CTRL)
              || (s_axi_araddr == FCTS_OFF_EVENT)
              || (s_axi_araddr == FCTS_OFF_STATUS)
              || (s_axi_araddr == FCTS_OFF_IRQ_STAT)
              || (s_axi_araddr == FCTS_OFF_IRQ_MASK)
              || (s_axi_araddr == FCTS_OFF_CONN_TMO);
    wire [31:0] rd_mux =
        (s_axi_araddr == FCTS_OFF_CTRL) ? rd_ctrl :
        (s_axi_araddr == FCTS_OFF_STATUS) ? rd_status :
        (s_axi_araddr == FCTS_OFF_IRQ_STAT) ? {29'h0, stat_q} :
        (s_axi_araddr == FCTS_OFF_IRQ_MASK) ? {29'h0, mask_q} :
        (s_axi_araddr == FCTS_OFF_CONN_TMO) ? {16'h0, conn_tmo_q} :
        32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !ar_take && !s_axi_arready;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= ra_ok ? 2'b00 : 2'b10;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ==========================================================
    // checks
    chk_idle_offline: assert property (@(posedge aclk) disable iff (!aresetn)
        lose_idle |=> comm_lost) // see RL10
        else $error("offline idle did not raise comm_lost");
    chk_idle_online: assert property (@(posedge aclk) disable iff (!aresetn)
        (ev_idle && idle_act_q && !comm_lost && !lose) |=> !comm_lost) // see RL11
        else $error("online idle raised comm_lost");
    chk_expire_lost: assert property (@(posedge aclk) disable iff (!aresetn)
        (expired && !control_event) |=> comm_lost) // see RL8
        else $error("expiry without comm_lost");
    chk_unconn_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        always_out |=> comm_lost) // see RL4
        else $error("unconnected zero not timed out");
    chk_event_clears: assert property (@(posedge aclk) disable iff (!aresetn)
        control_event |=> !expired) // see RL5
        else $error("event did not clear supervision");
    chk_objreset_ev: assert property (@(posedge aclk) disable iff (!aresetn)
        ev[FCTS_EV_SUP_RESET] |-> control_event) // see RL6
        else $error("supervisor reset not an event");
    chk_force_ev: assert property (@(posedge aclk) disable iff (!aresetn)
        ev[FCTS_EV_FORCE_FAULT] |-> control_event) // see RL7
        else $error("force fault not an event");
    chk_never_tmo: assert property (@(posedge aclk) disable iff (!aresetn)
        (use_value && tmo_never && !use_conn) |-> !cnt_en) // see RL3
        else $error("65535 still counts");
    chk_conn_src: assert property (@(posedge aclk) disable iff (!aresetn)
        is_io |-> (limit == conn_tmo_q)) // see RL1
        else $error("cyclic not on connection timeout");
    chk_regain: assert property (@(posedge aclk) disable iff (!aresetn)
        (comm_lost && regain && !lose) |=> !comm_lost) // see RL14
        else $error("comm_lost not released");
    chk_idle_reset: assert property (@(posedge aclk)
        $rose(aresetn) |-> !idle_act_q) // see RL9
        else $error("idle action reset not zero");
endmodule : fcts_supervisor

// ===== hw/fcts_pkg.sv
// package: register map, field layout and timing for the timeout supervisor
package fcts_pkg;
    // ==========================================================
    // register byte offsets
    localparam logic [7:0] FCTS_OFF_CTRL = 8'h00;
    localparam logic [7:0] FCTS_OFF_EVENT = 8'h04;
    localparam logic [7:0] FCTS_OFF_STATUS = 8'h08;
    localparam logic [7:0] FCTS_OFF_IRQ_STAT = 8'h0c;
    localparam logic [7:0] FCTS_OFF_IRQ_MASK = 8'h10;
    localparam logic [7:0] FCTS_OFF_CONN_TMO = 8'h14;
    // ==========================================================
    // control register fields
    localparam int FCTS_CTRL_TMO_LSB = 0;
    localparam int FCTS_CTRL_IDLE_BIT = 16;
    localparam int FCTS_CTRL_CONN_LSB = 17;
    localparam int FCTS_CTRL_DROP_BIT = 19;
    localparam logic [15:0] FCTS_TMO_RESET = 16'h0000;
    localparam logic FCTS_IDLE_RESET = 1'b0;
    localparam logic [15:0] FCTS_TMO_NEVER = 16'hffff;
    // event register bits (write one to signal)
    localparam int FCTS_EV_ASSEMBLY = 0;
    localparam int FCTS_EV_RUN_FIRST = 1;
    localparam int FCTS_EV_RUN_SECOND = 2;
    localparam int FCTS_EV_NET_CTRL = 3;
    localparam int FCTS_EV_NET_REF = 4;
    localparam int FCTS_EV_FAULT_CLR = 5;
    localparam int FCTS_EV_SPEED_REF = 6;
    localparam int FCTS_EV_TORQUE_REF = 7;
    localparam int FCTS_EV_SUP_RESET = 8;
    localparam int FCTS_EV_FORCE_FAULT = 9;
    localparam int FCTS_EV_IDLE = 10;
    localparam int FCTS_EV_RUN_NOTE = 11;
    localparam int FCTS_EV_CONN_EXPIRE = 12;
    localparam int FCTS_EV_WIDTH = 13;
    // interrupt bits (status register shares lost and timeout at bits 0 and 1 only)
    localparam int FCTS_IRQ_LOST = 0;
    localparam int FCTS_IRQ_TIMEOUT = 1;
    localparam int FCTS_IRQ_IDLE = 2;
    localparam int FCTS_IRQ_WIDTH = 3;
    // ==========================================================
    // connection kinds
    typedef enum logic [1:0] {
        FCTS_CONN_IO,
        FCTS_CONN_CONNECTED,
        FCTS_CONN_UNCONNECTED,
        FCTS_CONN_NONE
    } fcts_conn_e;
    // ==========================================================
    // timing: 100 ms supervision tick at 50 MHz
    localparam int FCTS_CLK_HZ = 50_000_000;
    localparam int FCTS_TICK_MS = 100;
    localparam int FCTS_TICK_CYCLES = FCTS_CLK_HZ / 1000 * FCTS_TICK_MS;
endpackage : fcts_pkg

// ===== hw/fcts_prescaler.sv
// prescaler: one-cycle enable pulse every tick period
module fcts_prescaler
    import fcts_pkg::*;
#(
    parameter int TICK_CYCLES = FCTS_TICK_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic restart,
    output logic tick
);
    // ==========================================================
    // counter
    logic [22:0] cnt_q;
    wire at_end = (cnt_q == 23'(TICK_CYCLES - 1));

    // restart realigns the phase so a full period follows each event
    always_ff @(posedge aclk) begin
        if (!aresetn || restart || at_end) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 23'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick <= 1'b0;
        end else begin
            tick <= at_end && !restart;
        end
    end
endmodule : fcts_prescaler

// ===== hw/fcts_timeout_counter.sv
// timeout counter: counts ticks since last event, flags expiry
module fcts_timeout_counter (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clear,
    input wire logic tick,
    input wire logic [15:0] limit,
    input wire logic enable,
    output logic expired
);
    // ==========================================================
    // tick count, saturates at the limit
    logic [15:0] cnt_q;
    wire reached = (cnt_q >= limit);

    always_ff @(posedge aclk) begin
        if (!aresetn || clear) begin
            cnt_q <= '0;
        end else if (tick && enable && !reached) begin
            cnt_q <= cnt_q + 16'h1;
        end
    end

    // expiry is a level while the count sits at the limit
    always_ff @(posedge aclk) begin
        if (!aresetn || clear) begin
            expired <= 1'b0;
        end else begin
            expired <= enable && reached;
        end
    end
endmodule : fcts_timeout_counter

// ===== tb/fcts_drive_model.sv
// drive-side model: counts each loss of communication it is told about
module fcts_drive_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic comm_lost,
    output int lost_count
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // edge counter
    logic seen_q;
    // the reaction itself is left to the drive, here only counted
    always_ff @(posedge aclk) begin
        seen_q <= aresetn ? comm_lost : 1'b0;
        if (!aresetn) begin
            lost_count <= 0;
        end else if (comm_lost && !seen_q) begin
            lost_count <= lost_count + 1;
        end
    end
endmodule : fcts_drive_model

// ===== tb/fcts_supervisor_tb_top.sv
// testbench: axi4-lite stimulus, read scoreboard, supervision scenarios
module fcts_supervisor_tb_top;
    import fcts_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TK = 10;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, comm_lost, irq;
    int lost_count, n_mismatch, num_checks, base;
    logic [33:0] notes[$];
    logic [31:0] rng;
    // ==========================================================
    // clock, reset, instances
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    fcts_supervisor #(.TICK_CYCLES(TK)) u_dut (.aclk(aclk),
        .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .comm_lost(comm_lost), .irq(irq));
    fcts_drive_model u_drive (.aclk(aclk), .aresetn(aresetn),
        .comm_lost(comm_lost), .lost_count(lost_count));
    // ==========================================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [31:0] ctl(input logic [15:0] t,
        input logic idle, input logic [1:0] kind);
        return {13'h0000, kind, idle, t};
    endfunction : ctl
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic close_out;
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er = 2'b00);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            n++;
        end while (!(bvalid === 1'b1 && bready) && n < 200);
        bready <= 1'b0;
        // a hung response counts as a mismatch as well
        check({31'h0, n >= 200, bresp}, {32'h0, er});
    endtask : wr
    task automatic ev(input int b);
        wr(FCTS_OFF_EVENT, 32'h1 << b);
    endtask : ev
    // expected read answer is noted before the request goes out
    task automatic rd(input logic [7:0] a, input logic [33:0] exp);
        int n;
        n = 0;
        notes.push_back(exp);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            n++;
        end while (!(rvalid === 1'b1 && rready) && n < 200);
        rready <= 1'b0;
        if (n >= 200) n_mismatch++;
    endtask : rd
    // bounded wait for the loss indication to reach a level
    task automatic wait_lost(input logic v, input int lim);
        int n;
        n = 0;
        while (comm_lost !== v && n < lim) begin
            @(posedge aclk);
            #1;
            n++;
        end
        check(34'(comm_lost), 34'(v));
    endtask : wait_lost
    task automatic hold(input int c, input logic v);
        repeat (c) @(posedge aclk);
        #1;
        check(34'(comm_lost), 34'(v));
    endtask : hold
    // ==========================================================
    // scoreboard: oldest note against each read answer
    always @(posedge aclk) begin
        if (rvalid === 1'b1 && rready) begin
            check({rresp, rdata}, notes.pop_front());
        end
    end
    initial begin
        #(20 * 20000);
        n_mismatch++;
        close_out();
    end
    // ==========================================================
    // main sequence
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        n_mismatch = 0;
        num_checks = 0;
        rng = 32'd89032;
        aresetn = 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd(FCTS_OFF_CTRL, {2'b00, ctl(16'h0000, 1'b0, 2'd3)});
        rd(FCTS_OFF_EVENT, 34'h0);
        rd(8'h18, {2'b10, 32'h0});
        wr(8'h18, 32'h0, 2'b10);
        // unconnected with zero: lost at once, run note does not help
        wr(FCTS_OFF_CTRL, ctl(16'h0000, 1'b0, 2'd2));
        wait_lost(1'b1, 20);
        ev(FCTS_EV_RUN_NOTE);
        hold(5, 1'b1);
        // every control event restarts a three tick supervision
        wr(FCTS_OFF_CTRL, ctl(16'd3, 1'b0, 2'd2));
        ev(FCTS_EV_ASSEMBLY);
        wait_lost(1'b0, 5);
        for (int i = 0; i <= FCTS_EV_FORCE_FAULT; i++) begin
            rng = lfsr(rng);
            repeat (int'(rng[2:0])) @(posedge aclk);
            // random filler in the unused upper event bits
            wr(FCTS_OFF_EVENT, (32'h1 << i) | {rng[18:0], 13'h0000});
            check(34'(comm_lost), 34'h0);
        end
        base = lost_count;
        hold(12, 1'b0);
        wait_lost(1'b1, 60);
        // the drive model counts the rise one edge later
        @(posedge aclk);
        #1;
        check(34'(lost_count), 34'(base + 1));
        ev(FCTS_EV_SPEED_REF);
        wait_lost(1'b0, 5);
        // all ones never expires
        wr(FCTS_OFF_CTRL, ctl(16'hffff, 1'b0, 2'd2));
        ev(FCTS_EV_TORQUE_REF);
        hold(300, 1'b0);
        // cyclic and connected-zero follow the connection timeout
        wr(FCTS_OFF_CONN_TMO, 32'd2);
        for (int k = 0; k < 2; k++) begin
            wr(FCTS_OFF_CTRL, ctl(k ? 16'h0000 : 16'hffff, 1'b0, 2'(k)));
            ev(FCTS_EV_ASSEMBLY);
            wait_lost(1'b0, 5);
            wait_lost(1'b1, 40);
        end
        // watchdog action expiry, cleared by a run note
        wr(FCTS_OFF_CONN_TMO, 32'd0);
        wr(FCTS_OFF_CTRL, ctl(16'h0000, 1'b0, 2'd0));
        ev(FCTS_EV_RUN_NOTE);
        wait_lost(1'b0, 5);
        ev(FCTS_EV_CONN_EXPIRE);
        wait_lost(1'b1, 5);
        ev(FCTS_EV_RUN_NOTE);
        wait_lost(1'b0, 5);
        // idle off-line loses, with interrupt raise, mask and clear
        wr(FCTS_OFF_IRQ_STAT, 32'h7);
        ev(FCTS_EV_IDLE);
        wait_lost(1'b1, 5);
        rd(FCTS_OFF_IRQ_STAT, 34'h5);
        hold(2, 1'b1);
        check(34'(irq), 34'h0);
        wr(FCTS_OFF_IRQ_MASK, 32'h7);
        hold(2, 1'b1);
        check(34'(irq), 34'h1);
        ev(FCTS_EV_RUN_NOTE);
        wr(FCTS_OFF_IRQ_STAT, 32'h7);
        hold(2, 1'b0);
        check(34'(irq), 34'h0);
        // idle on-line keeps communication up
        wr(FCTS_OFF_CTRL, ctl(16'h0000, 1'b1, 2'd0));
        ev(FCTS_EV_IDLE);
        hold(5, 1'b0);
        close_out();
    end
endmodule : fcts_supervisor_tb_top
